// ==== dcc_pkg.sv ====
// dcc_pkg: constants for the dual comparator control block
// assumes an Avalon-MM slave with 32-bit data, byte addresses
package dcc_pkg;
  localparam int ADDR_W = 8;
  // printed offset 0x1f is not word aligned: kept as index, byte addr = 4x
  localparam logic [ADDR_W-1:0] CFG_INDEX = 8'h1f;
  localparam logic [ADDR_W-1:0] CFG_ADDR = 8'h7c;
  localparam logic [ADDR_W-1:0] IRQ_STAT_ADDR = 8'h80;
  localparam logic [ADDR_W-1:0] IRQ_MASK_ADDR = 8'h84;
  localparam logic [ADDR_W-1:0] PIN_STAT_ADDR = 8'h88;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int CFG_OUT_B = 7;
  localparam int CFG_OUT_A = 6;
  localparam int CFG_INV_B = 5;
  localparam int CFG_INV_A = 4;
  localparam int CFG_SWITCH = 3;
  localparam int CFG_MODE_HI = 2;
  localparam logic [2:0] MODE_RESET = 3'b000;
  localparam logic [2:0] MODE_ONE_IND = 3'b001;
  localparam logic [2:0] MODE_VREF = 3'b010;
  localparam logic [2:0] MODE_COMMON = 3'b011;
  localparam logic [2:0] MODE_OUT_MUX = 3'b110;
  localparam logic [2:0] MODE_OFF = 3'b111;
  // status bits: 0 output change, 1 mode change
  localparam int STAT_W = 2;
  localparam int SYNC_STAGES = 3;
  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;
endpackage : dcc_pkg

// ==== dcc_sync.sv ====
// dcc_sync: three-stage synchroniser with second/third agreement
// assumes asynchronous inputs from the analog comparators
`timescale 1ns/100ps
module dcc_sync
  import dcc_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input wire logic clk, // system clock
  input wire logic sys_rst, // async reset, high
  input wire logic [WIDTH-1:0] async_in, // raw inputs
  output logic [WIDTH-1:0] sync_out // filtered level
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] val;
  } dcc_sync_t;
  dcc_sync_t q;
  dcc_sync_t next_q;
  if (WIDTH < 1) begin : g_bad_width
    $error("dcc_sync width must be positive");
  end
  always_comb begin
    next_q = q;
    next_q.s1 = async_in;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < WIDTH; i++) begin
      // a change counts once stages two and three agree
      if (q.s2[i] == q.s3[i]) next_q.val[i] = q.s3[i];
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) q <= '0;
    else q <= next_q;
  end
  assign sync_out = q.val;
endmodule : dcc_sync

// ==== dcc_ctrl.sv ====
// dcc_ctrl: configuration, muxing and interrupt logic for two comparators
// assumes Avalon-MM master with waitrequest; analog cores outside
`timescale 1ns/100ps
module dcc_ctrl
  import dcc_pkg::*;
(
  input wire logic clk, // system clock, 125 MHz
  input wire logic sys_rst, // async reset, high
  input wire logic [ADDR_W-1:0] avs_address, // byte address
  input wire logic avs_read, // read strobe
  input wire logic avs_write, // write strobe
  input wire logic [31:0] avs_writedata, // write data
  input wire logic [3:0] avs_byteenable, // byte lanes
  output logic [31:0] avs_readdata, // read data
  output logic avs_waitrequest, // stall
  input wire logic [1:0] cmp_raw, // analog cores, plus > minus
  input wire logic [4:0] port_a_direction, // 1 = input, pins 0-4
  output logic [1:0] cmp_enable, // comparator power
  output logic [1:0] cmp_a_sel, // a: 0 pin0,1 pin3,2 vref,3 gnd
  output logic [1:0] cmp_b_sel, // b: 0 pin1,1 pin2,2 vref,3 gnd
  output logic [1:0] cmp_a_plus_sel, // a plus: 0 pin3,1 pin2,2 vref
  output logic [1:0] cmp_b_plus_sel, // b plus: 0 pin2,1 vref
  output logic [4:0] pin_analog, // pin held as analog input
  output logic [1:0] pin_out_en, // pins 3,4 driven
  output logic [1:0] pin_out_val, // pins 3,4 level
  output logic comparator_irq // level interrupt
);
  typedef struct packed {
    logic [7:0] cfg;
    logic [1:0] seen_out;
    logic [STAT_W-1:0] stat;
    logic [STAT_W-1:0] mask;
    logic ack;
    logic stall;
    logic [31:0] rdata;
    logic [1:0] en;
    logic [1:0] a_sel;
    logic [1:0] b_sel;
    logic [1:0] a_plus;
    logic [1:0] b_plus;
    logic [4:0] analog;
    logic [1:0] oen;
    logic [1:0] oval;
    logic irq;
  } dcc_ctrl_t;

  dcc_ctrl_t q;
  dcc_ctrl_t next_q;
  logic [1:0] cmp_sync;
  logic [1:0] cmp_out;
  logic [2:0] mode;
  logic req;
  logic wr_now;
  logic rd_now;

  dcc_sync #(
    .WIDTH(2)
  ) u_sync (
    .clk(clk),
    .sys_rst(sys_rst),
    .async_in(cmp_raw),
    .sync_out(cmp_sync)
  );

  assign mode = q.cfg[CFG_MODE_HI:0];
  assign req = avs_read | avs_write;
  // one wait cycle: access completes on the edge where ack is high
  assign wr_now = avs_write & q.ack;
  assign rd_now = avs_read & q.ack;

  always_comb begin
    logic [7:0] new_cfg;
    logic switch_b;
    new_cfg = q.cfg;
    switch_b = 1'b0;
    next_q = q;
    next_q.ack = req & ~q.ack;
    // stall is high except in the completing cycle, straight from a flop
    next_q.stall = ~(req & ~q.ack);
    // inversion stage, forced low in the reset and off modes
    cmp_out[0] = (mode == MODE_OFF || mode == MODE_RESET) ? 1'b0 :
      cmp_sync[0] ^ q.cfg[CFG_INV_A];
    cmp_out[1] = (mode == MODE_OFF || mode == MODE_RESET) ? 1'b0 :
      cmp_sync[1] ^ q.cfg[CFG_INV_B];
    next_q.cfg[CFG_OUT_A] = cmp_out[0];
    next_q.cfg[CFG_OUT_B] = cmp_out[1];
    if (wr_now && avs_address == CFG_ADDR && avs_byteenable[0]) begin
      // only bits 5-0 writable; outputs stay read-only
      next_q.cfg[5:0] = avs_writedata[5:0];
      if (avs_writedata[2:0] != mode) next_q.stat[1] = 1'b1;
    end
    // read or write of config ends mismatch
    if (q.ack && req && avs_address == CFG_ADDR) begin
      // a read ends the mismatch for the value software actually got
      next_q.seen_out = avs_read ? q.rdata[CFG_OUT_B:CFG_OUT_A] :
        q.cfg[CFG_OUT_B:CFG_OUT_A];
    end
    if (wr_now && avs_address == IRQ_MASK_ADDR && avs_byteenable[0]) begin
      next_q.mask = avs_writedata[STAT_W-1:0];
    end
    if (wr_now && avs_address == IRQ_STAT_ADDR && avs_byteenable[0]) begin
      next_q.stat = next_q.stat & ~avs_writedata[STAT_W-1:0];
      // mismatch still present: re-sets at once
      if (q.cfg[CFG_OUT_B:CFG_OUT_A] != q.seen_out) begin
        next_q.stat[0] = 1'b1;
      end
    end
    // set wins over clear
    if (q.cfg[CFG_OUT_B:CFG_OUT_A] != q.seen_out) begin
      next_q.stat[0] = 1'b1;
    end
    if (wr_now && avs_address == CFG_ADDR && avs_byteenable[0] &&
        avs_writedata[2:0] != mode) begin
      next_q.stat[1] = 1'b1;
    end
    next_q.rdata = UNMAPPED_DATA;
    // fetched in the stall cycle, stands while stall is low
    if (avs_read && !q.ack) begin
      unique case (avs_address)
        CFG_ADDR: next_q.rdata = {24'h00_0000, q.cfg};
        IRQ_STAT_ADDR: next_q.rdata = {30'h0000_0000, q.stat};
        IRQ_MASK_ADDR: next_q.rdata = {30'h0000_0000, q.mask};
        PIN_STAT_ADDR: next_q.rdata = {30'h0000_0000, cmp_sync};
        default: next_q.rdata = UNMAPPED_DATA;
      endcase
    end
    // muxing from the mode field
    new_cfg = next_q.cfg;
    switch_b = new_cfg[CFG_SWITCH];
    next_q.en = 2'b11;
    next_q.a_sel = 2'd0;
    next_q.b_sel = 2'd0;
    next_q.a_plus = 2'd0;
    next_q.b_plus = 2'd0;
    next_q.analog = 5'b0_1111;
    next_q.oen = 2'b00;
    next_q.oval = 2'b00;
    unique case (new_cfg[CFG_MODE_HI:0])
      MODE_RESET: begin
        next_q.en = 2'b00;
        next_q.analog = 5'b0_1111;
      end
      MODE_ONE_IND: begin
        // a minus from pin 0 or pin 3 by the switch bit
        next_q.a_sel = switch_b ? 2'd1 : 2'd0;
        next_q.a_plus = 2'd1;
        next_q.b_sel = 2'd0;
        next_q.b_plus = 2'd0;
        next_q.oen = 2'b01;
      end
      MODE_VREF: begin
        next_q.a_sel = switch_b ? 2'd1 : 2'd0;
        next_q.b_sel = switch_b ? 2'd1 : 2'd0;
        next_q.a_plus = 2'd2;
        next_q.b_plus = 2'd1;
      end
      MODE_COMMON: begin
        next_q.a_plus = 2'd1;
        next_q.b_plus = 2'd0;
        next_q.oen = 2'b11;
        next_q.analog = 5'b0_0111;
      end
      3'b100: begin
        next_q.a_plus = 2'd0;
        next_q.b_plus = 2'd0;
      end
      3'b101: begin
        next_q.en = 2'b10;
        next_q.a_sel = 2'd3;
        next_q.analog = 5'b0_0110;
      end
      MODE_OUT_MUX: begin
        next_q.a_plus = 2'd1;
        next_q.b_plus = 2'd0;
        next_q.oen = 2'b11;
        next_q.analog = 5'b0_0111;
      end
      MODE_OFF: begin
        next_q.en = 2'b00;
        next_q.analog = 5'b0_0000;
      end
    endcase
    // direction bits still gate the output pins
    next_q.oen = next_q.oen & ~port_a_direction[4:3];
    next_q.oval = cmp_out;
    next_q.irq = |(next_q.stat & next_q.mask);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      q <= '0;
      q.cfg <= CFG_RESET;
      q.analog <= 5'b0_1111;
      q.stall <= 1'b1;
    end else begin
      q <= next_q;
    end
  end

  assign avs_readdata = q.rdata;
  assign avs_waitrequest = q.stall;
  assign cmp_enable = q.en;
  assign cmp_a_sel = q.a_sel;
  assign cmp_b_sel = q.b_sel;
  assign cmp_a_plus_sel = q.a_plus;
  assign cmp_b_plus_sel = q.b_plus;
  assign pin_analog = q.analog;
  assign pin_out_en = q.oen;
  assign pin_out_val = q.oval;
  assign comparator_irq = q.irq;

  chk_flag_on_change: assert property (@(posedge clk) disable iff (sys_rst)
    q.cfg[7:6] != q.seen_out |=> q.stat[0])
    else $error("output change did not set flag");
  chk_out_readonly: assert property (@(posedge clk) disable iff (sys_rst)
    wr_now && avs_address == CFG_ADDR |=> q.cfg[7:6] == $past(cmp_out))
    else $error("output bits took write data");
  chk_off_mode_power: assert property (@(posedge clk) disable iff (sys_rst)
    q.cfg[2:0] == MODE_OFF |-> q.en == 2'b00 && q.analog == 5'b0_0000)
    else $error("comparators powered in off mode");
  chk_reset_mode_analog: assert property (@(posedge clk)
    disable iff (sys_rst)
    q.cfg[2:0] == MODE_RESET |-> q.analog == 5'b0_1111 && q.en == 2'b00)
    else $error("reset mode not analog");
  chk_dir_gates_pin: assert property (@(posedge clk) disable iff (sys_rst)
    port_a_direction[3] |=> !q.oen[0])
    else $error("pin driven while direction is input");
  chk_mode_write: assert property (@(posedge clk) disable iff (sys_rst)
    wr_now && avs_address == CFG_ADDR && avs_byteenable[0]
    |=> q.cfg[2:0] == $past(avs_writedata[2:0]))
    else $error("mode field not written");
  chk_invert_path: assert property (@(posedge clk) disable iff (sys_rst)
    q.cfg[2:0] != MODE_OFF && q.cfg[2:0] != MODE_RESET
    |=> q.oval[0] == ($past(cmp_sync[0]) ^ $past(q.cfg[4])))
    else $error("inversion path wrong");
  chk_wait_one: assert property (@(posedge clk) disable iff (sys_rst)
    req && !q.ack |=> !avs_waitrequest || !req)
    else $error("waitrequest held too long");
  cov_mode_change: cover property (@(posedge clk) disable iff (sys_rst)
    q.stat[1] ##1 !q.stat[1]);
  cov_irq: cover property (@(posedge clk) disable iff (sys_rst)
    q.irq);
  cov_cfg_read: cover property (@(posedge clk) disable iff (sys_rst)
    rd_now && avs_address == CFG_ADDR);
  chk_clear_blocked: assert property (@(posedge clk) disable iff (sys_rst)
    wr_now && avs_address == IRQ_STAT_ADDR && avs_byteenable[0] &&
    q.cfg[7:6] != q.seen_out |=> q.stat[0])
    else $error("flag cleared during mismatch");
  chk_read_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    rd_now && avs_address == CFG_ADDR |-> avs_readdata[5:0] == q.cfg[5:0])
    else $error("config read data wrong");
  chk_off_outputs: assert property (@(posedge clk) disable iff (sys_rst)
    q.cfg[2:0] == MODE_OFF |=> q.cfg[7:6] == 2'b00)
    else $error("outputs not low in off mode");
  chk_mode_flag: assert property (@(posedge clk) disable iff (sys_rst)
    wr_now && avs_address == CFG_ADDR && avs_byteenable[0] &&
    avs_writedata[2:0] != q.cfg[2:0] |=> q.stat[1])
    else $error("mode change not flagged");
  chk_irq_level: assert property (@(posedge clk) disable iff (sys_rst)
    q.irq == |(q.stat & q.mask))
    else $error("interrupt level wrong");
  chk_stall_idle: assert property (@(posedge clk) disable iff (sys_rst)
    !req |=> avs_waitrequest)
    else $error("waitrequest low while idle");
  cov_clear_blocked: cover property (@(posedge clk) disable iff (sys_rst)
    wr_now && avs_address == IRQ_STAT_ADDR && q.cfg[7:6] != q.seen_out);
  cov_off_mode: cover property (@(posedge clk) disable iff (sys_rst)
    q.cfg[2:0] == MODE_OFF ##1 q.cfg[2:0] != MODE_OFF);
endmodule : dcc_ctrl

// ==== dcc_analog_src.sv ====
// dcc_analog_src: the two analog comparator cores seen at their outputs
// assumes the bench names the outcome and a response lag in cycles
`timescale 1ns/100ps
module dcc_analog_src (
  input wire logic clk, // system clock, times the lag
  input wire logic [1:0] want, // bit0 a, bit1 b, 1 = plus above minus
  input wire logic [3:0] lag, // response time in cycles
  output logic [1:0] cmp_raw // unsynchronised outputs
);
  int cnt = 0;
  initial cmp_raw = 2'b00;
  // outputs move between edges, like a free-running analog core
  always @(posedge clk) begin
    cnt = (want === cmp_raw) ? 0 : cnt + 1;
    if (cnt > lag) cmp_raw <= #3 want;
  end
endmodule : dcc_analog_src

// ==== test_dual_comparator_control.sv ====
// test_dual_comparator_control: random and corner tests of the config block
// assumes dcc_analog_src drives the comparator outputs, one 125 MHz clock
`timescale 1ns/100ps
module test_dual_comparator_control
  import dcc_pkg::*;
;
  logic clk, sys_rst, rd, wr, wreq, irq;
  logic [ADDR_W-1:0] adr;
  logic [31:0] wd, q, rdata;
  logic [4:0] dir, pan;
  logic [1:0] want, raw, en, oen, oval;
  logic [1:0] asel, bsel, apl, bpl;
  logic [3:0] lag, be;
  logic [7:0] c;
  int n_errors, compares;
  dcc_analog_src i_src (.clk(clk), .want(want), .lag(lag), .cmp_raw(raw));
  dcc_ctrl i_dut (.clk(clk), .sys_rst(sys_rst), .avs_address(adr),
    .avs_read(rd), .avs_write(wr), .avs_writedata(wd),
    .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
    .cmp_raw(raw), .port_a_direction(dir), .cmp_enable(en),
    .cmp_a_sel(asel), .cmp_b_sel(bsel), .cmp_a_plus_sel(apl),
    .cmp_b_plus_sel(bpl),
    .pin_analog(pan), .pin_out_en(oen), .pin_out_val(oval),
    .comparator_irq(irq));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrap_up;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one access; read data taken at the edge where stall is seen low
  task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
    adr <= a;
    wr <= w;
    rd <= ~w;
    wd <= {24'h00_0000, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  task automatic settle;
    repeat (24) @(posedge clk);
  endtask : settle
  // outputs read 0 in the reset and off modes
  function automatic logic [7:0] cfg_exp(logic [7:0] k, logic [1:0] r);
    logic off;
    off = k[2:0] == MODE_RESET || k[2:0] == MODE_OFF;
    return {off ? 2'b00 : r ^ k[5:4], k[5:0]};
  endfunction : cfg_exp
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    wrap_up();
  end
  initial begin
    sys_rst = 1'b1;
    rd = 1'b0;
    wr = 1'b0;
    adr = '0;
    wd = '0;
    dir = 5'h1f;
    want = 2'b00;
    lag = 4'h0;
    be = 4'h1;
    n_errors = 0;
    compares = 0;
    void'($urandom(96));
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(8'(pan), 8'h0f);
    chk(8'(en), 8'h00);
    bus(1'b0, CFG_ADDR, 8'h00);
    chk(q[7:0], CFG_RESET);
    bus(1'b0, 8'hf0, 8'h00);
    chk(q[7:0], UNMAPPED_DATA[7:0]);
    bus(1'b1, CFG_ADDR, 8'hff);
    bus(1'b0, CFG_ADDR, 8'h00);
    chk(q[7:0], 8'h3f);
    for (int m = 0; m < 8; m++) begin
      c = {2'b00, 3'($urandom), 3'(m)};
      want <= 2'($urandom);
      lag <= 4'($urandom);
      bus(1'b1, CFG_ADDR, c);
      settle();
      bus(1'b0, CFG_ADDR, 8'h00);
      chk(q[7:0], cfg_exp(c, want));
      if (m == 7) chk(8'(en), 8'h00);
      if (m == 3) chk(8'(en), 8'h03);
      if (m == 2) chk({asel, bsel, apl, bpl}, {{2{1'b0, c[3]}}, 4'h9});
      if (m == 1) chk({asel, bsel, apl, bpl}, {1'b0, c[3], 6'h04});
    end
    bus(1'b1, IRQ_MASK_ADDR, 8'h00);
    bus(1'b1, CFG_ADDR, 8'h03);
    dir <= 5'b00111;
    settle();
    bus(1'b0, CFG_ADDR, 8'h00);
    bus(1'b1, IRQ_STAT_ADDR, 8'h03);
    bus(1'b1, IRQ_MASK_ADDR, 8'h01);
    chk(8'(irq), 8'h00);
    want <= ~want;
    settle();
    chk(8'(irq), 8'h01);
    bus(1'b1, IRQ_STAT_ADDR, 8'h01);
    bus(1'b0, IRQ_STAT_ADDR, 8'h00);
    chk(q[7:0] & 8'h01, 8'h01);
    bus(1'b0, CFG_ADDR, 8'h00);
    bus(1'b1, IRQ_STAT_ADDR, 8'h01);
    bus(1'b0, IRQ_STAT_ADDR, 8'h00);
    chk(q[7:0] & 8'h01, 8'h00);
    chk(8'(irq), 8'h00);
    bus(1'b1, IRQ_MASK_ADDR, 8'h00);
    want <= ~want;
    settle();
    bus(1'b0, IRQ_STAT_ADDR, 8'h00);
    chk(q[7:0] & 8'h01, 8'h01);
    chk(8'(irq), 8'h00);
    c = {2'b00, 3'b010, MODE_OUT_MUX};
    bus(1'b1, CFG_ADDR, c);
    settle();
    chk(8'(oen), 8'h03);
    chk(8'(oval), 8'(want ^ 2'b01));
    dir <= 5'h1f;
    settle();
    chk(8'(oen), 8'h00);
    sys_rst <= 1'b1;
    @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    chk(8'(pan), 8'h0f);
    be <= 4'h0;
    bus(1'b1, CFG_ADDR, 8'h05);
    be <= 4'h1;
    bus(1'b0, CFG_ADDR, 8'h00);
    chk(q[7:0], CFG_RESET);
    wrap_up();
  end
endmodule : test_dual_comparator_control
